// ==== shared/asp_consts.svh ====
// Constants of the asynchronous serial port: register addresses, field
// positions, reset values and baud generator scaling.
// Assumes inclusion by bare name from the design and testbench files.
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH

// ==========================================================================
// Register addresses
`define ASP_ADDR_RXCTL     16'hfed0
`define ASP_ADDR_TXCTL     16'hfed1
`define ASP_ADDR_BAUD      16'hfed2
`define ASP_ADDR_TXDATA    16'hfed3
`define ASP_ADDR_RXDATA    16'hfed4

// ==========================================================================
// Receive control field positions
`define ASP_RX_PRESCALE    7
`define ASP_RX_START_EDGE_DETECT_ENABLE      6
`define ASP_RX_RUN         5
`define ASP_RX_STOP_ERROR_FLAG      4
`define ASP_RX_SPARE       3
`define ASP_RX_NINTH       2
`define ASP_RX_END         1
`define ASP_RX_IE          0

// ==========================================================================
// Transmit control field positions
`define ASP_TX_RUN         7
`define ASP_TX_NINE        6
`define ASP_TX_OE          5
`define ASP_TX_PUSHPULL    4
`define ASP_TX_SEVEN       3
`define ASP_TX_NINTH       2
`define ASP_TX_EMPTY       1
`define ASP_TX_IE          0

// ==========================================================================
// Reset values and timing
`define ASP_RESET_VALUE    8'h00
// Half bit period in thirds of a cycle per divisor step (32/3 and 8/3 per bit)
`define ASP_HALF_THIRDS_SLOW 13'h010
`define ASP_HALF_THIRDS_FAST 13'h004
// Thirds of a cycle gained per clock
`define ASP_THIRDS_PER_CYC 13'h003

`endif

// ==== shared/asp_pkg.sv ====
// Types of the asynchronous serial port.
// Assumes asp_consts.svh is on the include path.
package asp_pkg;

  // ==========================================================================
  // Register access from the CPU
  typedef struct packed {
    logic        wr;      // Write strobe, one cycle
    logic        bitop;   // Write comes from a bit-manipulation instruction
    logic [15:0] addr;    // Register address
    logic [7:0]  wdata;   // Write data
  } asp_sfr_req_s;

  typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SHIFT} asp_tx_e;

  // ==========================================================================
  // Module state records
  typedef struct packed {
    logic [12:0] acc;
    logic        tick;
  } asp_baud_s;

  typedef struct packed {
    logic pin;
    logic oe;
  } asp_pin_s;

  typedef struct packed {
    logic       prescale, start_edge_detect_enable, receive_run_flag, stop_error_flag, spare, rninth, receive_end_flag, receive_irq_enable;
    logic       transmit_run_bit, nine, tdoe, pushpull, seven, tninth, transmit_buffer_empty_flag, transmit_irq_enable;
    logic [7:0] baud;
    logic [7:0] transmit_data_register;
    logic [7:0] receive_data_register;
    logic       rx_prev, rx_ph, rx_last, rx_before;
    logic [3:0] rx_idx;
    logic [8:0] rx_data;
    asp_tx_e    tx_st;
    logic       tx_ph, tx_bit;
    logic [3:0] tx_idx;
    logic [8:0] transmit_shift_register;
    logic [7:0] rd_data;
    logic       rx_irq, tx_irq;
  } asp_state_s;

endpackage : asp_pkg

// ==== logic/asp_baud_gen.sv ====
// Fractional baud generator: emits a pulse every half bit period.
// Assumes clear is held while both directions are idle.
`timescale 1ns/100ps
`default_nettype none
`include "asp_consts.svh"

module asp_baud_gen #(
  parameter int DIV_W = 8
) (
  input  wire logic             clock_i,     // Core clock
  input  wire logic             rst_i,       // Synchronous reset, high
  input  wire logic             clear_i,     // Hold counter at zero
  input  wire logic             slow_i,      // Prescale select
  input  wire logic [DIV_W-1:0] divisor_i,   // Divisor n
  output logic                  half_tick_o  // One pulse per half bit
);
  import asp_pkg::*;

  asp_baud_s   state_ff;
  asp_baud_s   nxt_state;
  logic [12:0] thr;
  logic [12:0] sum;

  // ==========================================================================
  // Accumulate thirds of a cycle; avoids a drifting integer divider
  always_comb
  begin
    nxt_state = state_ff;
    thr = 13'((13'(divisor_i) + 13'h001) *
              (slow_i ? `ASP_HALF_THIRDS_SLOW : `ASP_HALF_THIRDS_FAST));
    sum = state_ff.acc + `ASP_THIRDS_PER_CYC;
    nxt_state.tick = 1'b0;
    if (clear_i)
    begin
      nxt_state.acc = 13'h000;
    end
    else if (sum >= thr)
    begin
      nxt_state.acc = sum - thr;
      nxt_state.tick = 1'b1;
    end
    else
    begin
      nxt_state.acc = sum;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign half_tick_o = state_ff.tick;

  // R24: counter reinit
  AST_BAUD_CLEAR: assert property (@(posedge clock_i) disable iff (rst_i) // R24
    clear_i |=> (state_ff.acc == 13'h000) && !state_ff.tick)
    else $error("baud counter not cleared while idle");

endmodule : asp_baud_gen
`default_nettype wire

// ==== logic/asp_pin_drive.sv ====
// Transmit pin driver: push-pull or open-drain with output enable.
// Assumes the pad resolves the wire level from pin and enable.
`timescale 1ns/100ps
`default_nettype none

module asp_pin_drive (
  input  wire logic clock_i,   // Core clock
  input  wire logic rst_i,     // Synchronous reset, high
  input  wire logic level_i,   // Line level to send
  input  wire logic enable_i,  // Output enabled
  input  wire logic pp_i,      // Push-pull when high, else open-drain
  output logic      pin_o,     // Pin output value
  output logic      pin_oe_o   // Pin output enable
);
  import asp_pkg::*;

  asp_pin_s state_ff;
  asp_pin_s nxt_state;

  // ==========================================================================
  // Open-drain only pulls low; a high level releases the pin
  always_comb
  begin
    nxt_state.pin = level_i;
    nxt_state.oe  = enable_i & (pp_i | ~level_i);
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      state_ff <= '{pin: 1'b1, oe: 1'b0};
    else
      state_ff <= nxt_state;
  end

  assign pin_o    = state_ff.pin;
  assign pin_oe_o = state_ff.oe;

  // R18: no drive when off
  AST_PIN_OFF: assert property (@(posedge clock_i) disable iff (rst_i) // R18
    !enable_i |=> !pin_oe_o)
    else $error("transmit pin driven while output disabled");

endmodule : asp_pin_drive
`default_nettype wire

// ==== logic/asp_serial_port.sv ====
// Asynchronous serial port core: control registers, receiver, transmitter.
// Assumes CPU register writes arrive as one-cycle strobes on the core clock
// and the receive line is already synchronous to that clock.
// Overview of operation
// R01: Baud period (n+1) times 32/3 or 8/3
// R02: Start edges detected only when detect enabled
// R03: Enabling detect with low line starts receive
// R04: Falling edge sets run flag, starts receive
// R05: Run flag self-clears; software clear aborts
// R06: Abort sets end, copies shift, stop error
// R07: Low stop bit sets sticky stop error
// R08: Ninth bit captured; abort takes second-last
// R09: Receive end sets flag and copies data
// R10: No new receive before current one ends
// R11: Receive interrupt when enable and end set
// R12: Software avoids bit operations while busy
// R13: Transmit run starts, self-clears, clear aborts
// R14: Continuous transmit restarts after one cycle
// R15: Bit operation same cycle blocks restart
// R16: Two select bits choose 9, 8, 7
// R17: One shared length; change only idle
// R18: Output enable, push-pull or open-drain pin
// R19: Buffer-empty set cycle after load
// R20: Clearing empty flag requests next character
// R21: Transmit interrupt when enable and empty set
// R22: Spare bit is plain storage
// R23: Software never programs divisor zero
// R24: Baud counter reinitialised when both idle
// R25: LSB first, one stop, two continuous
// R26: Seven-bit receive forces data bit 7 low
// R27: Receiver samples bits at mid period
`timescale 1ns/100ps
`default_nettype none
`include "asp_consts.svh"

module asp_serial_port #(
  parameter int DIV_W = 8
) (
  input  wire logic                 clock_i,    // Core clock, 200 MHz
  input  wire logic                 rst_i,      // Synchronous reset, high
  input  wire asp_pkg::asp_sfr_req_s req_i,     // Register access
  input  wire logic                 rx_line_i,  // Receive line level
  output logic [7:0]                rd_data_o,  // Read data, one cycle late
  output logic                      rx_irq_o,   // Receive interrupt request
  output logic                      tx_irq_o,   // Transmit interrupt request
  output logic                      tx_pin_o,   // Transmit pin value
  output logic                      tx_pin_oe_o // Transmit pin enable
);
  import asp_pkg::*;

  asp_state_s state_ff;
  asp_state_s nxt_state;
  logic       half_tick;
  logic       wr_rx, wr_tx, wr_baud, wr_tdat, wr_rdat;
  logic [7:0] w;
  logic [3:0] len;
  logic       rx_abort, tx_abort, rx_start;
  logic [3:0] nidx;
  logic [7:0] rx_word;

  // ==========================================================================
  // Address decode
  assign w       = req_i.wdata;
  assign wr_rx   = req_i.wr && (req_i.addr == `ASP_ADDR_RXCTL);
  assign wr_tx   = req_i.wr && (req_i.addr == `ASP_ADDR_TXCTL);
  assign wr_baud = req_i.wr && (req_i.addr == `ASP_ADDR_BAUD);
  assign wr_tdat = req_i.wr && (req_i.addr == `ASP_ADDR_TXDATA);
  assign wr_rdat = req_i.wr && (req_i.addr == `ASP_ADDR_RXDATA);

  // R16: data length select
  // The prohibited 1,1 setting falls back to eight bits
  assign len = (state_ff.nine && !state_ff.seven) ? 4'h9 :
               (!state_ff.nine && state_ff.seven) ? 4'h7 : 4'h8;

  // R26: seven-bit data clears bit 7
  assign rx_word = (len == 4'h7) ? {1'b0, state_ff.rx_data[6:0]} :
                   state_ff.rx_data[7:0];

  // R05: software clear of run aborts
  assign rx_abort = wr_rx && !w[`ASP_RX_RUN] && state_ff.receive_run_flag;
  // R13: software clear of run aborts
  assign tx_abort = wr_tx && !w[`ASP_TX_RUN] && state_ff.transmit_run_bit;

  // R02: edge detection only when enabled
  // R03: enabling with line low starts
  // R10: no start while receiving
  assign rx_start = !state_ff.receive_run_flag &&
                    ((state_ff.start_edge_detect_enable && state_ff.rx_prev && !rx_line_i) ||
                     (wr_rx && w[`ASP_RX_START_EDGE_DETECT_ENABLE] && !state_ff.start_edge_detect_enable && !rx_line_i));

  assign nidx = state_ff.tx_idx + 4'h1;

  // ==========================================================================
  // Baud generator
  // R24: reinit when both idle
  // R01: period scaled by prescale
  asp_baud_gen #(
    .DIV_W (DIV_W)
  ) u_baud (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .clear_i     (!state_ff.receive_run_flag && !state_ff.transmit_run_bit),
    .slow_i      (state_ff.prescale),
    .divisor_i   (state_ff.baud),
    .half_tick_o (half_tick)
  );

  // ==========================================================================
  // Next state: software writes first, hardware events after so sets win
  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.rx_prev = rx_line_i;
    // Receive control write; software can clear run but never set it
    if (wr_rx)
    begin
      nxt_state.prescale = w[`ASP_RX_PRESCALE];
      nxt_state.start_edge_detect_enable   = w[`ASP_RX_START_EDGE_DETECT_ENABLE];
      nxt_state.stop_error_flag   = w[`ASP_RX_STOP_ERROR_FLAG];
      // R22: plain storage bit
      nxt_state.spare    = w[`ASP_RX_SPARE];
      nxt_state.rninth   = w[`ASP_RX_NINTH];
      nxt_state.receive_end_flag   = w[`ASP_RX_END];
      nxt_state.receive_irq_enable    = w[`ASP_RX_IE];
      if (!w[`ASP_RX_RUN])
        nxt_state.receive_run_flag = 1'b0;
    end
    // Transmit control write
    if (wr_tx)
    begin
      nxt_state.transmit_run_bit     = w[`ASP_TX_RUN];
      nxt_state.nine     = w[`ASP_TX_NINE];
      nxt_state.tdoe     = w[`ASP_TX_OE];
      nxt_state.pushpull = w[`ASP_TX_PUSHPULL];
      nxt_state.seven    = w[`ASP_TX_SEVEN];
      nxt_state.tninth   = w[`ASP_TX_NINTH];
      nxt_state.transmit_buffer_empty_flag    = w[`ASP_TX_EMPTY];
      nxt_state.transmit_irq_enable   = w[`ASP_TX_IE];
    end
    if (wr_baud)
      nxt_state.baud = w;
    if (wr_tdat)
      nxt_state.transmit_data_register = w;
    if (wr_rdat)
      nxt_state.receive_data_register = w;

    // ------------------------------------------------------------------------
    // Receiver
    // R06: forced abort result
    if (rx_abort)
    begin
      nxt_state.receive_end_flag = 1'b1;
      nxt_state.receive_data_register   = rx_word;
      if (!state_ff.rx_last)
        nxt_state.stop_error_flag = 1'b1;
      // R08: abort takes second-last bit
      if (len == 4'h9)
        nxt_state.rninth = state_ff.rx_before;
    end
    // R04: falling edge starts receive
    else if (rx_start)
    begin
      nxt_state.receive_run_flag  = 1'b1;
      nxt_state.rx_ph   = 1'b0;
      nxt_state.rx_idx  = 4'h0;
      nxt_state.rx_data = 9'h000;
      nxt_state.rx_last = 1'b1;
    end
    // R27: sample at odd half ticks
    else if (state_ff.receive_run_flag && half_tick)
    begin
      nxt_state.rx_ph = !state_ff.rx_ph;
      if (!state_ff.rx_ph)
      begin
        nxt_state.rx_idx = state_ff.rx_idx + 4'h1;
        if (state_ff.rx_idx != 4'h0)
        begin
          nxt_state.rx_before = state_ff.rx_last;
          nxt_state.rx_last   = rx_line_i;
        end
        // R25: data arrives LSB first
        if ((state_ff.rx_idx != 4'h0) && (state_ff.rx_idx <= len))
          nxt_state.rx_data[state_ff.rx_idx - 4'h1] = rx_line_i;
        if (state_ff.rx_idx == len + 4'h1)
        begin
          // R05: self-clear at end
          nxt_state.receive_run_flag = 1'b0;
          // R09: end flag with data copy
          nxt_state.receive_end_flag = 1'b1;
          nxt_state.receive_data_register   = rx_word;
          // R08: ninth bit at end
          if (len == 4'h9)
            nxt_state.rninth = state_ff.rx_data[8];
          // R07: low stop bit flags error
          if (!rx_line_i)
            nxt_state.stop_error_flag = 1'b1;
        end
      end
    end

    // ------------------------------------------------------------------------
    // Transmitter
    // R13: abort stops the line at once
    if (tx_abort)
    begin
      nxt_state.tx_st  = TX_IDLE;
      nxt_state.tx_bit = 1'b1;
    end
    else
    begin
      unique case (state_ff.tx_st)
        TX_IDLE:
        begin
          // R13: write of one starts
          if (wr_tx && w[`ASP_TX_RUN])
            nxt_state.tx_st = TX_LOAD;
        end
        TX_LOAD:
        begin
          // R16: ninth bit from storage
          nxt_state.transmit_shift_register   = {state_ff.tninth, state_ff.transmit_data_register};
          // R19: empty flag after load
          nxt_state.transmit_buffer_empty_flag  = 1'b1;
          nxt_state.tx_st  = TX_SHIFT;
          nxt_state.tx_idx = 4'h0;
          nxt_state.tx_ph  = 1'b0;
          nxt_state.tx_bit = 1'b0;
        end
        TX_SHIFT:
        begin
          if (half_tick)
          begin
            nxt_state.tx_ph = !state_ff.tx_ph;
            if (state_ff.tx_ph)
            begin
              nxt_state.tx_idx = nidx;
              // R25: LSB first then stop
              if (nidx <= len)
              begin
                nxt_state.tx_bit = state_ff.transmit_shift_register[nidx - 4'h1];
              end
              else if (nidx == len + 4'h1)
              begin
                nxt_state.tx_bit = 1'b1;
              end
              // R20: cleared empty flag continues
              else if ((nidx == len + 4'h2) && !state_ff.transmit_buffer_empty_flag)
              begin
                nxt_state.tx_bit = 1'b1;
              end
              else if (nidx == len + 4'h2)
              begin
                nxt_state.transmit_run_bit  = 1'b0;
                nxt_state.tx_st = TX_IDLE;
              end
              // R15: bit operation blocks restart
              else if (wr_tx && req_i.bitop)
              begin
                nxt_state.transmit_run_bit  = 1'b0;
                nxt_state.tx_st = TX_IDLE;
              end
              // R14: one-cycle gap restart
              else
              begin
                nxt_state.transmit_run_bit  = 1'b1;
                nxt_state.tx_st = TX_LOAD;
              end
            end
          end
        end
      endcase
    end

    // ------------------------------------------------------------------------
    // Interrupt requests follow the flags in the same cycle
    // R11: receive request
    nxt_state.rx_irq = nxt_state.receive_irq_enable & nxt_state.receive_end_flag;
    // R21: transmit request
    nxt_state.tx_irq = nxt_state.transmit_irq_enable & nxt_state.transmit_buffer_empty_flag;

    // Read data; unmapped addresses read zero
    unique case (req_i.addr)
      `ASP_ADDR_RXCTL:  nxt_state.rd_data = {state_ff.prescale, state_ff.start_edge_detect_enable,
                                             state_ff.receive_run_flag, state_ff.stop_error_flag,
                                             state_ff.spare, state_ff.rninth,
                                             state_ff.receive_end_flag, state_ff.receive_irq_enable};
      `ASP_ADDR_TXCTL:  nxt_state.rd_data = {state_ff.transmit_run_bit, state_ff.nine,
                                             state_ff.tdoe, state_ff.pushpull,
                                             state_ff.seven, state_ff.tninth,
                                             state_ff.transmit_buffer_empty_flag, state_ff.transmit_irq_enable};
      `ASP_ADDR_BAUD:   nxt_state.rd_data = state_ff.baud;
      `ASP_ADDR_TXDATA: nxt_state.rd_data = state_ff.transmit_data_register;
      `ASP_ADDR_RXDATA: nxt_state.rd_data = state_ff.receive_data_register;
      default:          nxt_state.rd_data = 8'h00;
    endcase
  end

  // ==========================================================================
  // State register; line-facing bits reset to idle high
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      state_ff         <= '0;
      state_ff.rx_prev <= 1'b1;
      state_ff.rx_last <= 1'b1;
      state_ff.tx_bit  <= 1'b1;
      state_ff.tx_st   <= TX_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================================
  // Pin driver
  // R18: enable and output type
  asp_pin_drive u_pin (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .level_i  (state_ff.tx_bit),
    .enable_i (state_ff.tdoe),
    .pp_i     (state_ff.pushpull),
    .pin_o    (tx_pin_o),
    .pin_oe_o (tx_pin_oe_o)
  );

  assign rd_data_o = state_ff.rd_data;
  assign rx_irq_o  = state_ff.rx_irq;
  assign tx_irq_o  = state_ff.tx_irq;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  AST_TX_EMPTY_AFTER_LOAD: assert property ( // R19
    (state_ff.tx_st == TX_LOAD) && !tx_abort |=> state_ff.transmit_buffer_empty_flag && state_ff.transmit_run_bit)
    else $error("empty flag not set after transmit load");

  AST_RX_IRQ_RAISE: assert property ( // R11
    $rose(state_ff.receive_end_flag) && state_ff.receive_irq_enable |-> rx_irq_o)
    else $error("receive interrupt missing");

  AST_RX_ABORT_END: assert property ( // R06
    rx_abort |=> state_ff.receive_end_flag && !state_ff.receive_run_flag)
    else $error("receive abort did not set end flag");

  AST_TX_ABORT_IDLE: assert property ( // R13
    tx_abort |=> (state_ff.tx_st == TX_IDLE) ##1 tx_pin_o)
    else $error("transmit abort did not idle the line");

  AST_NO_DETECT_WHEN_OFF: assert property ( // R02
    !state_ff.start_edge_detect_enable && !state_ff.receive_run_flag && !wr_rx |=> !state_ff.receive_run_flag)
    else $error("receive started with detection disabled");

  AST_LOW_LINE_START: assert property ( // R03
    wr_rx && w[`ASP_RX_START_EDGE_DETECT_ENABLE] && !state_ff.start_edge_detect_enable && !rx_line_i && !state_ff.receive_run_flag
    |=> state_ff.receive_run_flag)
    else $error("enabling detection on low line did not start");

  AST_SEVEN_BIT_CLEAR: assert property ( // R26
    $fell(state_ff.receive_run_flag) && (len == 4'h7) && !wr_rdat |-> !state_ff.receive_data_register[7])
    else $error("seven-bit receive left data bit 7 set");

  AST_STOP_ERR_STICKY: assert property ( // R07
    state_ff.stop_error_flag && !wr_rx |=> state_ff.stop_error_flag)
    else $error("stop error flag cleared by hardware");

  AST_TX_IDLE_HIGH: assert property ( // R18
    (state_ff.tx_st == TX_IDLE) |-> state_ff.tx_bit)
    else $error("transmit line low while idle");

  AST_TX_IRQ_RAISE: assert property ( // R21
    $rose(state_ff.transmit_buffer_empty_flag) && state_ff.transmit_irq_enable |-> tx_irq_o)
    else $error("transmit interrupt missing");

endmodule : asp_serial_port
`default_nettype wire

// ==== verif/asp_remote_model.sv ====
// Remote serial device: sends frames to the port and listens to its line.
// Assumes the bench resolves the transmit pin with a pull-up.
`timescale 1ns/100ps
`default_nettype none

module asp_remote_model #(
  parameter int BIT = 32
) (
  input  wire logic       clock_i,   // Core clock
  input  wire logic       tx_line_i, // Resolved device transmit line
  output logic            line_o,    // Line into device receiver
  output logic [7:0]      word_o     // Last character heard
);
  initial
  begin
    line_o = 1'b1;
    word_o = 8'h00;
  end

  // =======================================================
  // Sender
  // start, LSB first, stop
  task automatic send(input logic [8:0] d, input int nb, input logic stp);
    logic v;
    for (int i = 0; i <= nb + 1; i++)
    begin
      v = (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : stp;
      @(posedge clock_i);
      line_o <= v;
      repeat (BIT - 1) @(posedge clock_i);
    end
    // Idle level is high once the frame ends
    @(posedge clock_i);
    line_o <= 1'b1;
  endtask : send

  // =======================================================
  // Listener, samples each bit at mid period
  always
  begin
    @(negedge tx_line_i);
    repeat (BIT + BIT / 2) @(posedge clock_i);
    for (int i = 0; i < 8; i++)
    begin
      word_o[i] = tx_line_i;
      repeat (BIT) @(posedge clock_i);
    end
  end
endmodule : asp_remote_model
`default_nettype wire

// ==== verif/async_serial_port_control_tb_top.sv ====
// Testbench of the serial port: register tasks and frame scenarios.
// Assumes divisor 2, slow prescale: 32 cycles per bit.
`timescale 1ns/100ps
`default_nettype none
`include "asp_consts.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end

module async_serial_port_control_tb_top;
  import asp_pkg::*;
  logic          clock_i = 1'b0;
  logic          rst_i   = 1'b1;
  asp_sfr_req_s  req     = '0;
  wire logic     rx_line;
  wire logic     tx_line;
  logic [7:0]    rd_data;
  logic          rx_irq, tx_irq, tx_pin, tx_oe;
  logic [7:0]    heard;
  int            n_fail  = 0;
  int            n_checks = 0;

  initial forever #2.5 clock_i = ~clock_i;
  // Open-drain needs a pull-up on the wire
  assign tx_line = (tx_oe === 1'b1) ? tx_pin : 1'b1;

  asp_serial_port asp_serial_port_i (.clock_i(clock_i), .rst_i(rst_i), .req_i(req),
    .rx_line_i(rx_line), .rd_data_o(rd_data), .rx_irq_o(rx_irq), .tx_irq_o(tx_irq),
    .tx_pin_o(tx_pin), .tx_pin_oe_o(tx_oe));
  asp_remote_model asp_remote_model_i (.clock_i(clock_i), .tx_line_i(tx_line),
    .line_o(rx_line), .word_o(heard));

  // =======================================================
  // Register access
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_i);
    // byte writes only, never bit operations
    req <= '{wr: 1'b1, bitop: 1'b0, addr: a, wdata: d};
    @(posedge clock_i);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clock_i);
    req.addr <= a;
    @(posedge clock_i);
    @(posedge clock_i);
    #1 `CHK(rd_data, e)
  endtask : rd

  // Bounded wait on one of the interrupt lines
  task automatic wait_irq(input bit tx, input logic e);
    int k;
    k = 0;
    // Sample away from the edge that launches the request
    @(negedge clock_i);
    while (((tx ? tx_irq : rx_irq) !== 1'b1) && k < 1000)
    begin
      @(negedge clock_i);
      k++;
    end
    `CHK((tx ? tx_irq : rx_irq), e)
  endtask : wait_irq

  task automatic rx_frame(input logic [8:0] d, input int nb, input logic stp,
                          input logic e);
    fork
      asp_remote_model_i.send(d, nb, stp);
    join_none
    wait_irq(1'b0, e);
    wait fork;
  endtask : rx_frame

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  // Watchdog well beyond the few frames run here
  initial
  begin
    #200000;
    n_fail++;
    final_report();
  end

  // =======================================================
  // Test sequence
  initial
  begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(`ASP_ADDR_RXCTL, 8'h00);
    rd(`ASP_ADDR_TXCTL, 8'h00);
    rd(16'hfed5, 8'h00);
    // Spare bit stores, run bit refuses a write of one
    wr(`ASP_ADDR_RXCTL, 8'h28);
    rd(`ASP_ADDR_RXCTL, 8'h08);
    $display("test registers done");
    wr(`ASP_ADDR_BAUD, 8'h02);
    wr(`ASP_ADDR_RXCTL, 8'h81);
    rx_frame(9'h0a5, 8, 1'b1, 1'b0);
    rd(`ASP_ADDR_RXCTL, 8'h81);
    $display("test detect off done");
    wr(`ASP_ADDR_RXCTL, 8'hc1);
    rx_frame(9'h0a5, 8, 1'b1, 1'b1);
    rd(`ASP_ADDR_RXDATA, 8'ha5);
    rd(`ASP_ADDR_RXCTL, 8'hc3);
    wr(`ASP_ADDR_RXCTL, 8'hc1);
    rx_frame(9'h03c, 8, 1'b0, 1'b1);
    rd(`ASP_ADDR_RXCTL, 8'hd3);
    $display("test receive done");
    // Seven-bit length clears data bit 7
    wr(`ASP_ADDR_TXCTL, 8'h08);
    wr(`ASP_ADDR_RXCTL, 8'hc1);
    rx_frame(9'h0ff, 7, 1'b1, 1'b1);
    rd(`ASP_ADDR_RXDATA, 8'h7f);
    $display("test seven bit done");
    // Abort after four data bits, detection off so the tail is ignored
    wr(`ASP_ADDR_RXCTL, 8'hc1);
    fork
      asp_remote_model_i.send(9'h00f, 8, 1'b1);
    join_none
    repeat (150) @(posedge clock_i);
    wr(`ASP_ADDR_RXCTL, 8'h81);
    wait fork;
    rd(`ASP_ADDR_RXCTL, 8'h83);
    rd(`ASP_ADDR_RXDATA, 8'h0f);
    $display("test receive abort done");
    // Push-pull send with interrupt on buffer empty
    wr(`ASP_ADDR_TXDATA, 8'h3c);
    wr(`ASP_ADDR_TXCTL, 8'hb1);
    wait_irq(1'b1, 1'b1);
    repeat (400) @(posedge clock_i);
    `CHK(heard, 8'h3c)
    rd(`ASP_ADDR_TXCTL, 8'h33);
    `CHK(tx_oe, 1'b1)
    `CHK(tx_pin, 1'b1)
    $display("test transmit done");
    // Continuous send: clear the empty flag while the first character runs
    wr(`ASP_ADDR_TXDATA, 8'h55);
    wr(`ASP_ADDR_TXCTL, 8'hb1);
    wait_irq(1'b1, 1'b1);
    wr(`ASP_ADDR_TXDATA, 8'ha5);
    wr(`ASP_ADDR_TXCTL, 8'hb1);
    wait_irq(1'b1, 1'b1);
    `CHK(heard, 8'h55)
    repeat (400) @(posedge clock_i);
    `CHK(heard, 8'ha5)
    rd(`ASP_ADDR_TXCTL, 8'h33);
    $display("test continuous transmit done");
    final_report();
  end
endmodule : async_serial_port_control_tb_top
`default_nettype wire
